// ### gpsc_top.sv
// The register offsets and the strobed register port are this design's own decisions.
`timescale 1ns/100ps
module gpsc_top
#(
   parameter bit DUAL_MODE = 1'b1 // platform supports legacy and os-directed modes
)
(
   input wire logic clk_sys, // 100 MHz system clock
   input wire logic arst_n, // asynchronous reset, active low
   input wire gpsc_pkg::gpsc_bus_t busReq, // register port request
   output logic [gpsc_pkg::DATA_W-1:0] rdata_q, // read data, cycle after read
   input wire logic [gpsc_pkg::EVT_W-1:0] evtPin, // raw event pins
   output logic osIrq_q, // os_visible_irq, level
   output logic mgmtIrq_q, // transparent_mgmt_irq, level
   output logic cpuRun_q, // processors may execute
   output logic [gpsc_pkg::SLPTYP_W-1:0] sleepLevel_q, // active sleep level, zero if none
   output logic modeSelect_q // os_mode_select as software sees it
);
   import gpsc_pkg::*;

   // write decode
   function automatic logic hitWr(input gpsc_bus_t b, input logic [ADDR_W-1:0] ofs);
      hitWr = b.wr && (b.addr == ofs);
   endfunction

   // event synchroniser chain and filtered level
   logic [EVT_W-1:0] evtS1_q, evtS2_q, evtS3_q; // three-stage sampling
   logic [EVT_W-1:0] evtLvl_q, evtLvl_d; // settled pin level
   logic [EVT_W-1:0] evtActive; // input at active level

   // software-visible storage
   logic [EVT_W-1:0] sticky_q, sticky_d; // sticky status
   logic [EVT_W-1:0] irqEn_q; // interrupt enables
   logic [EVT_W-1:0] wakeEn_q; // wake enables
   logic [SLPTYP_W-1:0] slpTyp_q; // sleep_type_field, read-back
   logic mode_q, mode_d; // os_mode_select storage

   // state machine
   gpsc_state_t state_q, state_d;
   logic [3:0] swCnt_q, swCnt_d; // mode switch timer

   // decoded strobes
   logic wrSticky, wrCtrl, wrIrqEn, wrCmd, wrWakeEn;
   logic cmdEnter, cmdExit; // command port codes seen
   logic trigWrite; // sleep_trigger written as one
   logic [SLPTYP_W-1:0] trigType; // type written with trigger
   logic trigValid; // type names a supported state
   logic [EVT_W-1:0] pending; // enabled sticky events
   logic anyPending, wakeHit;
   logic modeRead; // mode bit as read
   logic [7:0] queryVal; // handler index
   logic [DATA_W-1:0] readMux;
   logic [DATA_W-1:0] ctrlRead;

   // sampling: first stage feeds only the second
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         // idle level, so an active-low input does not look active after reset
         evtS1_q <= RST_EVT_IDLE;
         evtS2_q <= RST_EVT_IDLE;
         evtS3_q <= RST_EVT_IDLE;
         evtLvl_q <= RST_EVT_IDLE;
      end
      else
      begin
         evtS1_q <= evtPin;
         evtS2_q <= evtS1_q;
         evtS3_q <= evtS2_q;
         evtLvl_q <= evtLvl_d;
      end
   end

   // per-bit glitch filter: level moves only when stages two and three agree
   genvar gi;
   generate
      for (gi = 0; gi < EVT_W; gi++)
      begin : gFilt
         assign evtLvl_d[gi] = (evtS2_q[gi] == evtS3_q[gi]) ? evtS3_q[gi] : evtLvl_q[gi];
      end
   endgenerate

   // polarity per input; level, not edge, drives the sticky bit
   assign evtActive = ~(evtLvl_q ^ EVT_ACTIVE_HIGH); // see R4

   // address decode
   assign wrSticky = hitWr(busReq, OFS_STICKY);
   assign wrCtrl = hitWr(busReq, OFS_CTRL);
   assign wrIrqEn = hitWr(busReq, OFS_IRQEN);
   assign wrCmd = hitWr(busReq, OFS_CMD);
   assign wrWakeEn = hitWr(busReq, OFS_WAKEEN);

   // command port codes
   assign cmdEnter = wrCmd && (busReq.wdata[7:0] == MODE_ENTER_CODE); // see R11
   assign cmdExit = wrCmd && (busReq.wdata[7:0] == MODE_EXIT_CODE); // see R13

   // trigger is write-only: an action, never stored
   assign trigWrite = wrCtrl && busReq.wdata[CTRL_SLPEN_BIT]; // see R1, R7
   assign trigType = busReq.wdata[CTRL_SLPTYP_LSB +: SLPTYP_W]; // see R17
   assign trigValid = (trigType >= SLPTYP_S1) && (trigType <= SLPTYP_SOFT_OFF); // see R14

   // set wins over a clear in the same cycle; written zero leaves bits alone
   assign sticky_d = (sticky_q & ~(wrSticky ? busReq.wdata[EVT_W-1:0] : RST_EVT))
                     | evtActive; // see R4, R5

   // pending and wake detection
   assign pending = sticky_q & irqEn_q;
   assign anyPending = |pending;
   assign wakeHit = |(sticky_q & wakeEn_q); // see R16

   // an os-only part pins the mode bit high whatever is stored
   assign modeRead = DUAL_MODE ? mode_q : 1'b1; // see R8

   // query value: lowest pending event, plus one; zero means none
   always_comb
   begin
      queryVal = 8'h00;
      for (int i = EVT_W - 1; i >= 0; i--)
      begin
         if (pending[i])
         begin
            queryVal = 8'(i + 1); // see R6
         end
      end
   end

   // control read: trigger bit position reads zero, reserved bits zero
   assign ctrlRead = {{(DATA_W - CTRL_SLPTYP_LSB - SLPTYP_W){1'b0}},
                      slpTyp_q,
                      {(CTRL_SLPTYP_LSB - 1){1'b0}},
                      modeRead}; // see R2, R24

   // read mux; unmapped offsets read zero
   assign readMux = (busReq.addr == OFS_STICKY) ? {24'h000000, sticky_q} :
                    (busReq.addr == OFS_CTRL) ? ctrlRead :
                    (busReq.addr == OFS_IRQEN) ? {24'h000000, irqEn_q} :
                    (busReq.addr == OFS_LIVE) ? {24'h000000, evtActive} : // see R3
                    (busReq.addr == OFS_QUERY) ? {24'h000000, queryVal} :
                    (busReq.addr == OFS_STATE) ? {29'h00000000, state_q} :
                    (busReq.addr == OFS_WAKEEN) ? {24'h000000, wakeEn_q} :
                    32'h00000000; // see R24

   // global state machine
   always_comb
   begin
      state_d = state_q;
      mode_d = mode_q;
      swCnt_d = swCnt_q;
      case (state_q)
         ST_MECH_OFF:
         begin
            // boot: dual parts come up legacy, os-only parts working
            state_d = DUAL_MODE ? ST_LEGACY : ST_WORKING; // see R9, R18, R22
            mode_d = ~DUAL_MODE; // see R9, R18
         end
         ST_LEGACY:
         begin
            if (cmdEnter)
            begin
               state_d = ST_SWITCH; // see R11
               swCnt_d = 4'h0;
            end
         end
         ST_SWITCH:
         begin
            // mode bit set on the same edge control returns
            if (swCnt_q == SWITCH_LAST)
            begin
               state_d = ST_WORKING; // see R12
               mode_d = 1'b1;
            end
            else
            begin
               swCnt_d = swCnt_q + 4'h1;
            end
         end
         ST_WORKING:
         begin
            if (cmdExit && DUAL_MODE)
            begin
               state_d = ST_LEGACY; // see R13, R22
               mode_d = 1'b0;
            end
            else if (trigWrite && trigValid)
            begin
               // relies on wake enables being written first
               state_d = (trigType == SLPTYP_SOFT_OFF) ? ST_SOFT_OFF : ST_SLEEP; // see R15, R17
            end
         end
         ST_SLEEP:
         begin
            if (wakeHit)
            begin
               state_d = ST_WORKING; // see R16
            end
         end
         ST_SOFT_OFF:
         begin
            // leaving soft off is a full reboot through mechanical off
            if (wakeHit)
            begin
               state_d = ST_MECH_OFF; // see R18
            end
         end
         default:
         begin
            state_d = ST_MECH_OFF;
         end
      endcase
   end

   // state and mode storage
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_q <= ST_MECH_OFF;
         mode_q <= 1'b0;
         swCnt_q <= 4'h0;
      end
      else
      begin
         state_q <= state_d;
         mode_q <= mode_d;
         swCnt_q <= swCnt_d;
      end
   end

   // software registers
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         sticky_q <= RST_EVT;
         irqEn_q <= RST_EVT;
         wakeEn_q <= RST_EVT;
         slpTyp_q <= RST_SLPTYP;
      end
      else
      begin
         sticky_q <= sticky_d;
         if (wrIrqEn)
         begin
            irqEn_q <= busReq.wdata[EVT_W-1:0]; // see R2
         end
         if (wrWakeEn)
         begin
            wakeEn_q <= busReq.wdata[EVT_W-1:0]; // see R2
         end
         if (wrCtrl)
         begin
            slpTyp_q <= trigType; // see R2
         end
      end
   end

   // outputs; interrupt routing follows the mode bit as read
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rdata_q <= 32'h00000000;
         osIrq_q <= 1'b0;
         mgmtIrq_q <= 1'b0;
         cpuRun_q <= 1'b0;
         sleepLevel_q <= RST_SLPTYP;
         modeSelect_q <= 1'b0;
      end
      else
      begin
         rdata_q <= busReq.rd ? readMux : 32'h00000000;
         // held as long as any enabled sticky bit stays set: a shareable level
         osIrq_q <= modeRead && anyPending; // see R10, R20, R23, R25
         // mode-enter request is handled by management firmware
         mgmtIrq_q <= (!modeRead && anyPending) || (state_q == ST_SWITCH); // see R11, R21, R23
         // frozen context: no execution while switching, sleeping or off
         cpuRun_q <= (state_d == ST_WORKING) || (state_d == ST_LEGACY); // see R12, R19
         sleepLevel_q <= (state_d == ST_SLEEP || state_d == ST_SOFT_OFF) ?
                         ((state_q == ST_WORKING) ? trigType : sleepLevel_q) :
                         RST_SLPTYP; // see R14
         modeSelect_q <= DUAL_MODE ? mode_d : 1'b1;
      end
   end

   // checks
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!arst_n);

   sequence enterSeq;
      state_q == ST_LEGACY && cmdEnter;
   endsequence

   sequence switchDoneSeq;
      (state_q == ST_SWITCH && !mode_q)[*4] ##1 (state_q == ST_WORKING && mode_q);
   endsequence

   // reboot path out of soft off: one cycle in mechanical off, then boot
   sequence rebootSeq;
      state_q == ST_MECH_OFF ##1 state_q == (DUAL_MODE ? ST_LEGACY : ST_WORKING);
   endsequence

   // a written zero, or no write at all, must not drop it while the input is idle
   sticky_clear_a: assert property (sticky_q[0] && !evtActive[0] // see R5
      && !(wrSticky && busReq.wdata[0]) |=> sticky_q[0]) else $error("sticky bit lost");

   // no edge needed: a steady active level keeps setting the bit
   sticky_set_a: assert property (evtActive[1] |=> sticky_q[1]) // see R4
      else $error("sticky bit not set");

   os_irq_level_a: assert property (modeRead && anyPending |=> osIrq_q) // see R25
      else $error("os irq missing");

   // legacy software must never see an os-visible interrupt
   legacy_no_irq_a: assert property (!modeRead |=> !osIrq_q) // see R10
      else $error("os irq in legacy");

   mode_switch_a: assert property (enterSeq |=> switchDoneSeq) // see R12
      else $error("mode switch timing wrong");

   exit_mode_a: assert property (state_q == ST_WORKING && cmdExit && DUAL_MODE // see R13
      |=> state_q == ST_LEGACY && !mode_q) else $error("mode exit failed");

   // a trigger written just after waking may legally leave working again
   wake_return_a: assert property (state_q == ST_SLEEP && wakeHit // see R16
      |=> state_q == ST_WORKING && cpuRun_q) else $error("no wake");

   trig_readzero_a: assert property (busReq.rd && busReq.addr == OFS_CTRL // see R1
      |=> rdata_q[CTRL_SLPEN_BIT] == 1'b0) else $error("trigger reads one");

   // enables follow the last write one edge later
   readback_a: assert property (wrIrqEn // see R2
      |=> irqEn_q == $past(busReq.wdata[EVT_W-1:0])) else $error("enable readback wrong");

   sleep_halt_a: assert property (state_q == ST_SLEEP // see R19
      |=> !cpuRun_q || state_q == ST_WORKING) else $error("cpu runs asleep");

   // legacy mode sends pending events to the management side
   mgmt_legacy_a: assert property (!modeRead && anyPending |=> mgmtIrq_q) // see R23
      else $error("mgmt irq missing");

   // once the mode bit is set nothing reaches the management side
   mgmt_route_a: assert property (modeRead |=> !mgmtIrq_q) // see R21
      else $error("mgmt irq in os mode");

   // the boot edge settles the mode bit by platform kind and lets code run
   boot_mode_a: assert property (state_q == ST_MECH_OFF // see R9
      |=> modeSelect_q == ~DUAL_MODE && cpuRun_q) else $error("boot mode wrong");

   // an os-only part shows the mode bit set in every state after boot
   os_only_mode_a: assert property (!DUAL_MODE && state_q != ST_MECH_OFF // see R8
      |-> modeSelect_q) else $error("mode bit clear on os-only part");

   // a trigger with a supported type freezes code and reports the level
   sleep_entry_a: assert property (state_q == ST_WORKING && trigWrite && trigValid // see R14
      |=> sleepLevel_q == $past(trigType) && !cpuRun_q) else $error("sleep entry wrong");

   // unsupported types are stored but never start a transition
   type_refuse_a: assert property (state_q == ST_WORKING && trigWrite && !trigValid // see R14
      |=> state_q == ST_WORKING) else $error("bad sleep type accepted");

   // leaving soft off always passes through mechanical off and a fresh boot
   soft_off_reboot_a: assert property (state_q == ST_SOFT_OFF && wakeHit // see R18
      |=> rebootSeq) else $error("soft off exit wrong");

   // while switching, code is held and the mode bit still reads clear
   switch_hold_a: assert property (state_q == ST_SWITCH // see R12
      |-> !cpuRun_q && !modeSelect_q) else $error("control returned early");

   // the command-port event follows every cycle of the switch one edge later
   switch_event_a: assert property (state_q == ST_SWITCH |=> mgmtIrq_q) // see R11
      else $error("switch event missing");
endmodule

// ### gpsc_pkg.sv
// What this block does
// R1: writing one to trigger bit fires action
// R2: control bits read back last written value
// R3: live status bits show current signal level
// R4: sticky bits set by level, not edge
// R5: sticky bits clear only on written one
// R6: query value names event handler to run
// R7: sleep trigger sits at control bit 13
// R8: os-only platform always reads mode bit one
// R9: dual-mode platform boots legacy, mode bit zero
// R10: legacy mode raises no os-visible interrupts
// R11: mode-enter code on command port raises event
// R12: set mode bit, then return control
// R13: mode-exit code returns legacy, clears mode bit
// R14: one sleep state at a time, four levels
// R15: software enables wake, sets type, then triggers
// R16: enabled wake event returns to working
// R17: soft off entered via type plus trigger
// R18: soft off exit reboots, mode bit per platform
// R19: processors halted while sleeping or off
// R20: os-visible interrupt is a shareable level
// R21: dual-mode reroutes events on mode change
// R22: legacy state only on dual-mode hardware
// R23: mode clear routes to mgmt, set to os
// R24: reserved bits read zero, writes harmless
// R25: os irq held while enabled sticky bit set
package gpsc_pkg;
   // bus geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int EVT_W = 8; // number of event inputs

   // register offsets
   localparam logic [ADDR_W-1:0] OFS_STICKY = 8'h00; // sticky status, write one clears
   localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h04; // pm_control_reg
   localparam logic [ADDR_W-1:0] OFS_IRQEN = 8'h08; // interrupt enables
   localparam logic [ADDR_W-1:0] OFS_LIVE = 8'h0c; // live event levels
   localparam logic [ADDR_W-1:0] OFS_CMD = 8'h10; // legacy_command_port
   localparam logic [ADDR_W-1:0] OFS_QUERY = 8'h14; // query value
   localparam logic [ADDR_W-1:0] OFS_STATE = 8'h18; // global state
   localparam logic [ADDR_W-1:0] OFS_WAKEEN = 8'h1c; // wake enables

   // control register fields
   localparam int CTRL_MODE_BIT = 0; // os_mode_select
   localparam int CTRL_SLPTYP_LSB = 10; // sleep_type_field
   localparam int SLPTYP_W = 3;
   localparam int CTRL_SLPEN_BIT = 13; // sleep_trigger

   // sleep type encodings
   localparam logic [SLPTYP_W-1:0] SLPTYP_S1 = 3'h1;
   localparam logic [SLPTYP_W-1:0] SLPTYP_S4 = 3'h4;
   localparam logic [SLPTYP_W-1:0] SLPTYP_SOFT_OFF = 3'h5;

   // command port codes
   localparam logic [7:0] MODE_ENTER_CODE = 8'he1;
   localparam logic [7:0] MODE_EXIT_CODE = 8'h1e;

   // event polarity: one marks an active-high input
   localparam logic [EVT_W-1:0] EVT_ACTIVE_HIGH = 8'h0f;

   // reset values
   localparam logic [EVT_W-1:0] RST_EVT = 8'h00;
   // synchroniser starts at the idle level so no false event follows reset
   localparam logic [EVT_W-1:0] RST_EVT_IDLE = ~EVT_ACTIVE_HIGH;
   localparam logic [SLPTYP_W-1:0] RST_SLPTYP = 3'h0;

   // mode switch handling time
   localparam int CLK_PERIOD_NS = 10;
   localparam int SWITCH_TIME_NS = 40;
   localparam int SWITCH_CYCLES = (SWITCH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] SWITCH_LAST = 4'(SWITCH_CYCLES - 1);

   // global system states
   typedef enum logic [2:0] {
      ST_MECH_OFF,
      ST_LEGACY,
      ST_SWITCH,
      ST_WORKING,
      ST_SLEEP,
      ST_SOFT_OFF
   } gpsc_state_t;

   // register port request
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } gpsc_bus_t;
endpackage

// ### test_global_power_state_control.sv
`timescale 1ns/100ps
module test_global_power_state_control;
   import gpsc_pkg::*;
   // one table row: optional write, then a read and the word it should give
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic doWr;
      logic [DATA_W-1:0] wdata;
      logic [DATA_W-1:0] expData;
   } gpsc_row_t;
   logic clk_sys; // 100 MHz
   logic arst_n; // async reset, active low
   gpsc_bus_t busReq; // register port request
   logic [DATA_W-1:0] rdata; // read data
   logic [EVT_W-1:0] evtPin; // raw event pins
   logic osIrq; // os_visible_irq
   logic mgmtIrq; // transparent_mgmt_irq
   logic cpuRun; // processors may run
   logic [SLPTYP_W-1:0] sleepLevel; // active sleep level
   logic modeSelect; // os_mode_select
   logic osOnlyMode; // mode bit of the os-only instance
   logic osOnlyRun; // run flag of the os-only instance
   int num_errors = 0;
   int checked = 0;
   int n;
   // reserved, read-only and unmapped places mixed with plain read-back
   gpsc_row_t rows [9] = '{
      '{OFS_CTRL, 1'b1, 32'hffff_dfff, 32'h0000_1c00},
      '{OFS_CTRL, 1'b1, 32'h0000_2800, 32'h0000_0800},
      '{OFS_STATE, 1'b0, 32'h0, 32'h1},
      '{OFS_IRQEN, 1'b1, 32'hffff_ffa5, 32'h0000_00a5},
      '{OFS_WAKEEN, 1'b1, 32'hffff_ff3c, 32'h0000_003c},
      '{8'h20, 1'b1, 32'hffff_ffff, 32'h0},
      '{OFS_LIVE, 1'b1, 32'hffff_ffff, 32'h0},
      '{OFS_STICKY, 1'b1, 32'hffff_ffff, 32'h0},
      '{OFS_QUERY, 1'b0, 32'h0, 32'h0}};

   // dual-mode platform under test
   gpsc_top #(.DUAL_MODE(1'b1)) dut_u (.clk_sys(clk_sys), .arst_n(arst_n), .busReq(busReq),
      .rdata_q(rdata), .evtPin(evtPin), .osIrq_q(osIrq), .mgmtIrq_q(mgmtIrq),
      .cpuRun_q(cpuRun), .sleepLevel_q(sleepLevel), .modeSelect_q(modeSelect));
   // os-only platform, only its boot behaviour is watched
   gpsc_top #(.DUAL_MODE(1'b0)) dutOs_u (.clk_sys(clk_sys), .arst_n(arst_n), .busReq('0),
      .rdata_q(), .evtPin(8'hf0), .osIrq_q(), .mgmtIrq_q(), .cpuRun_q(osOnlyRun),
      .sleepLevel_q(), .modeSelect_q(osOnlyMode));

   // free-running clock
   initial
   begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   // compare a word
   task automatic checkWord(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
      checked++;
      if (got !== exp)
      begin
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
         num_errors++;
      end
   endtask

   // compare a flag
   task automatic checkFlag(input logic got, input logic exp);
      checkWord({31'h0, got}, {31'h0, exp});
   endtask

   // let k edges pass, then sample settled outputs
   task automatic tick(input int k);
      repeat (k) @(posedge clk_sys);
      #1;
   endtask

   // one-cycle write strobe; a gap edge follows so back-to-back calls never clash
   task automatic busWrite(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk_sys);
      busReq.addr <= a;
      busReq.wdata <= d;
      busReq.wr <= 1'b1;
      @(posedge clk_sys);
      busReq.wr <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic expectReg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
      @(posedge clk_sys);
      busReq.addr <= a;
      busReq.rd <= 1'b1;
      @(posedge clk_sys);
      busReq.rd <= 1'b0;
      #1;
      checkWord(rdata, exp);
   endtask

   // drive an event to its active or idle level, whatever its polarity
   task automatic setEvt(input int idx, input bit act);
      @(posedge clk_sys);
      evtPin[idx] <= act ~^ EVT_ACTIVE_HIGH[idx];
      tick(8);
   endtask

   // reset pulse, outputs quiet during it, boot state after it
   task automatic doReset;
      @(posedge clk_sys);
      arst_n <= 1'b0;
      tick(19);
      checkWord(32'({osIrq, mgmtIrq, cpuRun, sleepLevel, modeSelect}), 32'h0);
      @(posedge clk_sys);
      arst_n <= 1'b1;
      tick(2);
      checkFlag(modeSelect, 1'b0);
      checkFlag(cpuRun, 1'b1);
      checkFlag(osOnlyMode, 1'b1);
      checkFlag(osOnlyRun, 1'b1);
   endtask

   // command-port switch; the mode bit must rise together with the run flag
   task automatic enterOs;
      busWrite(OFS_CMD, {24'h0, MODE_ENTER_CODE});
      tick(1);
      checkFlag(mgmtIrq, 1'b1);
      checkFlag(cpuRun, 1'b0);
      n = 0;
      while (modeSelect !== 1'b1 && n < 10)
      begin
         tick(1);
         n++;
      end
      checkFlag(cpuRun, 1'b1);
      checkWord(32'(n), 32'(SWITCH_CYCLES - 1));
   endtask

   task automatic endTest(input string s);
      $display("test %s done", s);
   endtask

   task automatic give_verdict;
      $display("comparisons %0d, mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // a hang counts as a mismatch
   initial
   begin
      repeat (6000) @(posedge clk_sys);
      num_errors++;
      give_verdict;
   end

   // main sequence
   initial
   begin
      arst_n = 1'b0;
      busReq = '0;
      evtPin = 8'hf0;
      doReset;
      endTest("reset");
      foreach (rows[i])
      begin
         if (rows[i].doWr)
            busWrite(rows[i].addr, rows[i].wdata);
         expectReg(rows[i].addr, rows[i].expData);
      end
      endTest("register table");
      // legacy routing, live and sticky levels of both polarities
      setEvt(0, 1);
      checkFlag(mgmtIrq, 1'b1);
      checkFlag(osIrq, 1'b0);
      expectReg(OFS_LIVE, 32'h01);
      setEvt(5, 1);
      expectReg(OFS_QUERY, 32'h1);
      setEvt(0, 0);
      expectReg(OFS_LIVE, 32'h20);
      expectReg(OFS_STICKY, 32'h21);
      busWrite(OFS_STICKY, 32'hde);
      expectReg(OFS_STICKY, 32'h21);
      busWrite(OFS_STICKY, 32'h21);
      expectReg(OFS_STICKY, 32'h20);
      expectReg(OFS_QUERY, 32'h6);
      setEvt(5, 0);
      busWrite(OFS_STICKY, 32'h20);
      tick(2);
      checkFlag(mgmtIrq, 1'b0);
      endTest("legacy events");
      enterOs;
      busWrite(OFS_CMD, {24'h0, MODE_ENTER_CODE});
      tick(2);
      expectReg(OFS_STATE, 32'h3);
      endTest("mode enter");
      // os-directed routing, level held until cleared
      setEvt(0, 1);
      checkFlag(osIrq, 1'b1);
      checkFlag(mgmtIrq, 1'b0);
      setEvt(0, 0);
      checkFlag(osIrq, 1'b1);
      busWrite(OFS_STICKY, 32'h0);
      tick(2);
      checkFlag(osIrq, 1'b1);
      busWrite(OFS_STICKY, 32'h1);
      tick(2);
      checkFlag(osIrq, 1'b0);
      // a sticky bit without its enable stays silent
      setEvt(1, 1);
      checkFlag(osIrq, 1'b0);
      expectReg(OFS_STICKY, 32'h02);
      setEvt(1, 0);
      busWrite(OFS_STICKY, 32'h02);
      endTest("os events");
      // each sleep level; an event without wake enable must not wake
      for (int t = 1; t <= 4; t++)
      begin
         busWrite(OFS_CTRL, (32'(t) << CTRL_SLPTYP_LSB) | (32'h1 << CTRL_SLPEN_BIT));
         tick(1);
         checkWord(32'(sleepLevel), 32'(t));
         checkFlag(cpuRun, 1'b0);
         setEvt(0, 1);
         checkFlag(cpuRun, 1'b0);
         setEvt(2, 1);
         checkFlag(cpuRun, 1'b1);
         checkWord(32'(sleepLevel), 32'h0);
         setEvt(0, 0);
         setEvt(2, 0);
         busWrite(OFS_STICKY, 32'h05);
         expectReg(OFS_CTRL, (32'(t) << CTRL_SLPTYP_LSB) | 32'h1);
      end
      endTest("sleep levels");
      // trigger with an unsupported type is refused
      busWrite(OFS_CTRL, (32'h7 << CTRL_SLPTYP_LSB) | (32'h1 << CTRL_SLPEN_BIT));
      tick(1);
      checkFlag(cpuRun, 1'b1);
      expectReg(OFS_STATE, 32'h3);
      endTest("refused type");
      busWrite(OFS_CMD, {24'h0, MODE_EXIT_CODE});
      tick(1);
      checkFlag(modeSelect, 1'b0);
      expectReg(OFS_STATE, 32'h1);
      endTest("mode exit");
      enterOs;
      busWrite(OFS_CTRL, (32'(SLPTYP_SOFT_OFF) << CTRL_SLPTYP_LSB) | 32'h2000);
      tick(1);
      checkWord(32'(sleepLevel), 32'(SLPTYP_SOFT_OFF));
      checkFlag(cpuRun, 1'b0);
      setEvt(2, 1);
      tick(4);
      checkFlag(cpuRun, 1'b1);
      checkFlag(modeSelect, 1'b0);
      expectReg(OFS_STATE, 32'h1);
      setEvt(2, 0);
      endTest("soft off");
      doReset;
      endTest("second reset");
      give_verdict;
   end
endmodule
